// ---- rtl/rvi_pkg.sv ----
package rvi_pkg;

  localparam int NSLOT = 25;

  typedef logic [4:0] rvi_slot_type;
  typedef logic [7:0] rvi_byte_type;

  // reset categories seen by the value selector
  typedef enum logic [2:0] {
    RVI_CAT_POR,
    RVI_CAT_EXT,
    RVI_CAT_WDT,
    RVI_CAT_BOR,
    RVI_CAT_WAKE
  } rvi_cat_type;

  // encoding of the reset cause input
  localparam logic [2:0] RVI_CAUSE_POR = 3'h0;
  localparam logic [2:0] RVI_CAUSE_EXT = 3'h1;
  localparam logic [2:0] RVI_CAUSE_WDT = 3'h2;
  localparam logic [2:0] RVI_CAUSE_BOR = 3'h3;

  // register index per slot; byte address is four times the index
  localparam rvi_byte_type RVI_IDX [NSLOT] = '{
    8'h0b, 8'h0c, 8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h18,
    8'h19, 8'h1a, 8'h1f, 8'h81, 8'h85, 8'h86, 8'h8c, 8'h8e, 8'h92,
    8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9f};
  // implemented bits; all others read as zero
  localparam rvi_byte_type RVI_IMPL [NSLOT] = '{
    8'hff, 8'hf7, 8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h3f, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf7, 8'h0b, 8'hff,
    8'hf7, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h00, 8'hef};
  // power-on values, unknown bits taken as zero
  localparam rvi_byte_type RVI_POR [NSLOT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h08, 8'hff,
    8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // values on the other resets
  localparam rvi_byte_type RVI_OTH [NSLOT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h08, 8'hff,
    8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // bits kept unchanged on the other resets, except timer1 control and the BOR bit on a brown-out
  localparam rvi_byte_type RVI_KEEP [NSLOT] = '{
    8'h01, 8'h00, 8'h3f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00,
    8'h00, 8'h00, 8'hff, 8'hff, 8'h08, 8'h00, 8'h00};

  // slots with special handling
  localparam rvi_slot_type RVI_S_ICTL  = 5'h00;
  localparam rvi_slot_type RVI_S_PFLAG = 5'h01;
  localparam rvi_slot_type RVI_S_T1CTL = 5'h02;
  localparam rvi_slot_type RVI_S_TXDAT = 5'h09;
  localparam rvi_slot_type RVI_S_RXDAT = 5'h0a;
  localparam rvi_slot_type RVI_S_OPTS  = 5'h0c;
  localparam rvi_slot_type RVI_S_TRA   = 5'h0d;
  localparam rvi_slot_type RVI_S_PWR   = 5'h10;
  localparam rvi_slot_type RVI_S_EEUNL = 5'h17;
  localparam rvi_slot_type RVI_S_MISS  = 5'h1f;

  // field positions and constants
  localparam int RVI_GIE_BIT = 7;
  localparam int RVI_BOR_BIT = 0;
  localparam logic [12:0] RVI_PC_ZERO   = 13'h0000;
  localparam logic [12:0] RVI_PC_VECTOR = 13'h0004;
  localparam logic [12:0] RVI_PC_STEP   = 13'h0001;

endpackage

// ---- rtl/rvi_init_if.sv ----
`timescale 1ns/10ps
interface rvi_init_if;
  rvi_pkg::rvi_cat_type  cat;
  rvi_pkg::rvi_byte_type val  [rvi_pkg::NSLOT];
  rvi_pkg::rvi_byte_type keep [rvi_pkg::NSLOT];

  modport ctl (output cat, input val, input keep);
  modport sel (input cat, output val, output keep);
endinterface

// ---- rtl/rvi_init_sel.sv ----
`timescale 1ns/10ps
module rvi_init_sel
(
  // category in, per-slot values out
  rvi_init_if.sel init
);

  always_comb
  begin
    for (int s = 0; s < rvi_pkg::NSLOT; s++)
    begin
      case (init.cat)
        rvi_pkg::RVI_CAT_POR:
        begin
          init.val[s]  = rvi_pkg::RVI_POR[s];
          init.keep[s] = 8'h00;
        end
        rvi_pkg::RVI_CAT_EXT, rvi_pkg::RVI_CAT_WDT,
        rvi_pkg::RVI_CAT_BOR:
        begin
          init.val[s]  = rvi_pkg::RVI_OTH[s];
          init.keep[s] = rvi_pkg::RVI_KEEP[s];
        end
        default:
        begin
          // wake-up keeps everything; flags are merged later
          init.val[s]  = 8'h00;
          init.keep[s] = 8'hff;
        end
      endcase
    end
    if (init.cat == rvi_pkg::RVI_CAT_BOR)
    begin
      init.keep[rvi_pkg::RVI_S_T1CTL] = 8'h00;
      init.val[rvi_pkg::RVI_S_T1CTL]  = 8'h00;
      init.keep[rvi_pkg::RVI_S_PWR][rvi_pkg::RVI_BOR_BIT] = 1'b0;
      init.val[rvi_pkg::RVI_S_PWR][rvi_pkg::RVI_BOR_BIT]  = 1'b0;
    end
  end

endmodule

// ---- rtl/rvi_top.sv ----
`timescale 1ns/10ps
module rvi_top
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [9:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // reset cause from the reset controller
  input  wire logic        RESET_HOLD,
  input  wire logic [2:0]  RESET_CAUSE,
  // wake-up from sleep
  input  wire logic        WAKE_PULSE,
  input  wire logic        WAKE_BY_IRQ,
  input  wire logic [2:0]  WAKE_ICTL_SET,
  input  wire logic [7:0]  WAKE_PFLAG_SET,
  // peripheral status update on wake-up
  input  wire logic        PERIPH_UPD,
  input  wire logic [7:0]  PERIPH_IDX,
  input  wire logic [7:0]  PERIPH_MASK,
  input  wire logic [7:0]  PERIPH_DATA,
  // program counter load
  input  wire logic [12:0] CUR_PC,
  output logic             PC_LOAD,
  output logic      [12:0] PC_VALUE
);

  localparam int NS = rvi_pkg::NSLOT;

  rvi_init_if init ();

  rvi_init_sel u_sel
  (
    .init (init)
  );

  rvi_pkg::rvi_byte_type reg_q [NS];
  rvi_pkg::rvi_byte_type reg_d [NS];
  logic                  hold_q;
  logic                  ack_q;
  logic [31:0]           dat_q;
  logic                  pc_load_q;
  logic [12:0]           pc_q;

  // register slot for an index, miss when not mapped
  function automatic rvi_pkg::rvi_slot_type find_slot
  (
    input logic [7:0] idx
  );
    find_slot = rvi_pkg::RVI_S_MISS;
    for (int s = 0; s < NS; s++)
    begin
      if (rvi_pkg::RVI_IDX[s] == idx)
      begin
        find_slot = rvi_pkg::rvi_slot_type'(s);
      end
    end
  endfunction

  // cause code to category; unknown codes count as pin reset
  function automatic rvi_pkg::rvi_cat_type decode_cause
  (
    input logic [2:0] code
  );
    case (code)
      rvi_pkg::RVI_CAUSE_POR: decode_cause = rvi_pkg::RVI_CAT_POR;
      rvi_pkg::RVI_CAUSE_WDT: decode_cause = rvi_pkg::RVI_CAT_WDT;
      rvi_pkg::RVI_CAUSE_BOR: decode_cause = rvi_pkg::RVI_CAT_BOR;
      default:                decode_cause = rvi_pkg::RVI_CAT_EXT;
    endcase
  endfunction

  // reset and wake-up events
  wire release_w = hold_q & ~RESET_HOLD;
  wire wake_w    = WAKE_PULSE & ~hold_q & ~RESET_HOLD;
  wire apply_w   = release_w | wake_w;
  wire wake_irq_w = wake_w & WAKE_BY_IRQ;
  wire gie_w     = reg_q[rvi_pkg::RVI_S_ICTL][rvi_pkg::RVI_GIE_BIT];

  // category chosen in the release cycle
  assign init.cat = release_w ? decode_cause(RESET_CAUSE)
                              : rvi_pkg::RVI_CAT_WAKE;

  // peripheral update target
  wire rvi_pkg::rvi_slot_type per_slot_w = find_slot(PERIPH_IDX);
  wire per_w = wake_w & PERIPH_UPD &
               (per_slot_w != rvi_pkg::RVI_S_MISS);

  // bus decode
  wire rvi_pkg::rvi_slot_type bus_slot_w = find_slot(WB_ADR_I[9:2]);
  wire bus_hit_w = bus_slot_w != rvi_pkg::RVI_S_MISS;
  wire bus_req_w = WB_CYC_I & WB_STB_I & ~ack_q;
  // writes lose to a reset or wake-up in the same cycle
  wire wr_w = bus_req_w & WB_WE_I & WB_SEL_I[0] & bus_hit_w &
              ~apply_w & (bus_slot_w != rvi_pkg::RVI_S_RXDAT);
  wire rvi_pkg::rvi_slot_type rd_slot_w =
    bus_hit_w ? bus_slot_w : rvi_pkg::RVI_S_ICTL;
  // write-only registers read back as zero
  wire rd_ok_w = bus_hit_w & (bus_slot_w != rvi_pkg::RVI_S_TXDAT) &
                 (bus_slot_w != rvi_pkg::RVI_S_EEUNL);
  wire [7:0] rd_byte_w = rd_ok_w ? reg_q[rd_slot_w] : 8'h00;

  // program counter after reset or wake-up
  wire vec_w = wake_irq_w & gie_w;
  wire [12:0] pc_d = release_w ? rvi_pkg::RVI_PC_ZERO
                   : vec_w     ? rvi_pkg::RVI_PC_VECTOR
                               : CUR_PC + rvi_pkg::RVI_PC_STEP;

  always_comb
  begin
    logic [7:0] nxt;
    nxt = 8'h00;
    for (int s = 0; s < NS; s++)
    begin
      nxt = reg_q[s];
      // keep retained bits, load the rest
      if (apply_w)
      begin
        nxt = (reg_q[s] & init.keep[s]) | (init.val[s] & ~init.keep[s]);
      end
      if (wr_w && bus_slot_w == rvi_pkg::rvi_slot_type'(s))
      begin
        nxt = WB_DAT_I[7:0];
      end
      if (per_w && per_slot_w == rvi_pkg::rvi_slot_type'(s))
      begin
        nxt = (nxt & ~PERIPH_MASK) | (PERIPH_DATA & PERIPH_MASK);
      end
      // wake source flags, set after writes
      if (wake_irq_w && s == int'(rvi_pkg::RVI_S_ICTL))
      begin
        nxt = nxt | {5'h00, WAKE_ICTL_SET};
      end
      if (wake_irq_w && s == int'(rvi_pkg::RVI_S_PFLAG))
      begin
        nxt = nxt | WAKE_PFLAG_SET;
      end
      reg_d[s] = nxt & rvi_pkg::RVI_IMPL[s];
    end
  end

  always_ff @(posedge CLK)
  begin
    for (int s = 0; s < NS; s++)
    begin
      reg_q[s] <= RESET ? rvi_pkg::RVI_POR[s] : reg_d[s];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      hold_q <= 1'b0;
      ack_q  <= 1'b0;
      dat_q  <= 32'h0000_0000;
    end
    else
    begin
      hold_q <= RESET_HOLD;
      ack_q  <= bus_req_w;
      dat_q  <= bus_req_w ? {24'h00_0000, rd_byte_w} : dat_q;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pc_load_q <= 1'b0;
      pc_q      <= rvi_pkg::RVI_PC_ZERO;
    end
    else
    begin
      pc_load_q <= apply_w;
      pc_q      <= apply_w ? pc_d : pc_q;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign PC_LOAD  = pc_load_q;
  assign PC_VALUE = pc_q;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  AST_POR_VALUES:
    assert property (release_w && RESET_CAUSE == rvi_pkg::RVI_CAUSE_POR
      |=> reg_q[rvi_pkg::RVI_S_PWR] == rvi_pkg::RVI_POR[rvi_pkg::RVI_S_PWR]
          && reg_q[rvi_pkg::RVI_S_OPTS] == 8'hff)
    else $error("power-on values not loaded");

  AST_WAKE_FLAGS:
    assert property (wake_irq_w && !wr_w
      |=> (reg_q[rvi_pkg::RVI_S_ICTL][2:0] & $past(WAKE_ICTL_SET))
          == $past(WAKE_ICTL_SET))
    else $error("wake flag not set");

  AST_WAKE_VECTOR:
    assert property (wake_irq_w && gie_w
      |=> PC_LOAD && PC_VALUE == rvi_pkg::RVI_PC_VECTOR ##1 !PC_LOAD)
    else $error("interrupt vector not loaded");

  AST_BOR_FLAG:
    assert property (release_w && RESET_CAUSE == rvi_pkg::RVI_CAUSE_BOR
      |=> !reg_q[rvi_pkg::RVI_S_PWR][rvi_pkg::RVI_BOR_BIT])
    else $error("brown-out flag not cleared");

  AST_BOR_KEEP:
    assert property (release_w && RESET_CAUSE != rvi_pkg::RVI_CAUSE_BOR
      && RESET_CAUSE != rvi_pkg::RVI_CAUSE_POR
      |=> $stable(reg_q[rvi_pkg::RVI_S_PWR][rvi_pkg::RVI_BOR_BIT]))
    else $error("brown-out flag changed");

  AST_BOR_TIMER1:
    assert property (release_w && RESET_CAUSE == rvi_pkg::RVI_CAUSE_BOR
      |=> reg_q[rvi_pkg::RVI_S_T1CTL] == 8'h00)
    else $error("timer1 control not cleared");

  AST_PERIPH_UPD:
    assert property (per_w && per_slot_w != rvi_pkg::RVI_S_ICTL
      && per_slot_w != rvi_pkg::RVI_S_PFLAG
      |=> (reg_q[$past(per_slot_w)] & $past(PERIPH_MASK))
          == ($past(PERIPH_DATA) & $past(PERIPH_MASK)
              & rvi_pkg::RVI_IMPL[$past(per_slot_w)]))
    else $error("peripheral status not updated");

  AST_UNIMPL_ZERO:
    assert property (WB_DAT_O[31:8] == 24'h00_0000
      && reg_q[rvi_pkg::RVI_S_T1CTL][7:6] == 2'h0
      && (reg_q[rvi_pkg::RVI_S_PWR] & 8'hf4) == 8'h00)
    else $error("unimplemented bits not zero");

  AST_WDT_WAKE_KEEP:
    assert property (wake_w && !PERIPH_UPD
      |=> $stable(reg_q[rvi_pkg::RVI_S_OPTS])
          && $stable(reg_q[rvi_pkg::RVI_S_TRA]))
    else $error("retained register changed on wake-up");

  AST_OTHER_RESET:
    assert property (release_w && RESET_CAUSE == rvi_pkg::RVI_CAUSE_WDT
      |=> reg_q[rvi_pkg::RVI_S_TRA] == rvi_pkg::RVI_OTH[rvi_pkg::RVI_S_TRA])
    else $error("other-reset value not loaded");

  AST_RELEASE_PC:
    assert property ($fell(RESET_HOLD) && hold_q
      |=> PC_LOAD && PC_VALUE == rvi_pkg::RVI_PC_ZERO)
    else $error("reset not applied at release");

  AST_ACK_PULSE:
    assert property (WB_CYC_I && WB_STB_I && !ack_q
      |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not a single cycle");

  AST_POR_CTL_REGS:
    assert property (release_w && RESET_CAUSE == rvi_pkg::RVI_CAUSE_POR
      |=> reg_q[rvi_pkg::RVI_S_ICTL] == rvi_pkg::RVI_POR[rvi_pkg::RVI_S_ICTL]
          && reg_q[rvi_pkg::RVI_S_T1CTL]
             == rvi_pkg::RVI_POR[rvi_pkg::RVI_S_T1CTL])
    else $error("power-on control values not loaded");

  AST_WAKE_PFLAGS:
    assert property (wake_irq_w
      |=> (reg_q[rvi_pkg::RVI_S_PFLAG] & $past(WAKE_PFLAG_SET))
          == ($past(WAKE_PFLAG_SET) & rvi_pkg::RVI_IMPL[rvi_pkg::RVI_S_PFLAG]))
    else $error("peripheral wake flag not set");

  AST_WAKE_STEP:
    assert property (wake_w && !(WAKE_BY_IRQ && gie_w)
      |=> PC_LOAD && PC_VALUE == $past(CUR_PC) + rvi_pkg::RVI_PC_STEP)
    else $error("program counter not stepped on wake-up");

  AST_WAKE_GIE_KEEP:
    assert property (wake_w && !PERIPH_UPD
      |=> $stable(reg_q[rvi_pkg::RVI_S_ICTL][rvi_pkg::RVI_GIE_BIT]))
    else $error("global enable changed by wake-up");

  AST_PWR_WAKE_KEEP:
    assert property (wake_w && !PERIPH_UPD
      |=> $stable(reg_q[rvi_pkg::RVI_S_PWR]))
    else $error("power control changed by wake-up");

  AST_T1_OTHER_KEEP:
    assert property (release_w && RESET_CAUSE != rvi_pkg::RVI_CAUSE_BOR
      && RESET_CAUSE != rvi_pkg::RVI_CAUSE_POR
      |=> $stable(reg_q[rvi_pkg::RVI_S_T1CTL]))
    else $error("timer1 control changed by other reset");

  AST_UNIMPL_REGS:
    assert property ((reg_q[rvi_pkg::RVI_S_PFLAG]
      & ~rvi_pkg::RVI_IMPL[rvi_pkg::RVI_S_PFLAG]) == 8'h00
      && reg_q[rvi_pkg::RVI_S_EEUNL] == 8'h00)
    else $error("unimplemented register bits not zero");

  AST_RD_WO_ZERO:
    assert property (bus_req_w && !WB_WE_I && !rd_ok_w
      |=> WB_DAT_O == 32'h0000_0000)
    else $error("unmapped or write-only read not zero");

  AST_WRITE_LANDS:
    assert property (wr_w
      |=> reg_q[$past(bus_slot_w)] == ($past(WB_DAT_I[7:0])
          & rvi_pkg::RVI_IMPL[$past(bus_slot_w)]))
    else $error("register write not stored");

  AST_HOLD_NO_LOAD:
    assert property (RESET_HOLD |=> !PC_LOAD)
    else $error("load while reset is held");

  AST_ACK_IDLE:
    assert property (!WB_CYC_I |=> !WB_ACK_O)
    else $error("ack without a cycle");

  AST_DAT_HOLD:
    assert property (!bus_req_w |=> $stable(WB_DAT_O))
    else $error("read data changed without a request");

  AST_RXDAT_READONLY:
    assert property (bus_req_w && WB_WE_I
      && bus_slot_w == rvi_pkg::RVI_S_RXDAT && !apply_w
      |=> $stable(reg_q[rvi_pkg::RVI_S_RXDAT]))
    else $error("receive data accepted a write");

  AST_SEL_LOW_DROP:
    assert property (bus_req_w && WB_WE_I && !WB_SEL_I[0] && bus_hit_w
      && !apply_w
      |=> reg_q[$past(bus_slot_w)] == $past(reg_q[bus_slot_w]))
    else $error("write without low byte select stored");

endmodule

// ---- tb/rvi_top_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module rvi_top_tb;
  logic        clk, rst, cyc, stb, we, hold, wake, by_irq, upd, ack, pc_load;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_i, dat_o;
  logic [2:0]  cause, ictl;
  logic [7:0]  pflag, pidx, pmask, pdata, q;
  logic [12:0] cur_pc, pc_value;
  int          n_fail, n_tests, ncyc;
  // {writable, index, power-on value, readback after writing ff}
  localparam logic [24:0] ROWS [26] = '{
    25'h10b00ff, 25'h10c00f7, 25'h110003f, 25'h11100ff, 25'h112007f,
    25'h11500ff, 25'h11600ff, 25'h117003f, 25'h0180000, 25'h1190000,
    25'h11a0000, 25'h01f0000, 25'h181ffff, 25'h185ffff, 25'h186ffff,
    25'h18c00f7, 25'h18e080b, 25'h192ffff, 25'h0980200, 25'h19900ff,
    25'h19d0000, 25'h19f00ef, 25'h1200000, 25'h19a00ff, 25'h19b00ff,
    25'h19c000f};
  localparam logic [2:0] OTHER [3] = '{3'h1, 3'h2, 3'h5};

  rvi_top u_dut
  (
    .CLK            (clk),
    .RESET          (rst),
    .WB_CYC_I       (cyc),
    .WB_STB_I       (stb),
    .WB_WE_I        (we),
    .WB_ADR_I       (adr),
    .WB_SEL_I       (sel),
    .WB_DAT_I       (dat_i),
    .WB_DAT_O       (dat_o),
    .WB_ACK_O       (ack),
    .RESET_HOLD     (hold),
    .RESET_CAUSE    (cause),
    .WAKE_PULSE     (wake),
    .WAKE_BY_IRQ    (by_irq),
    .WAKE_ICTL_SET  (ictl),
    .WAKE_PFLAG_SET (pflag),
    .PERIPH_UPD     (upd),
    .PERIPH_IDX     (pidx),
    .PERIPH_MASK    (pmask),
    .PERIPH_DATA    (pdata),
    .CUR_PC         (cur_pc),
    .PC_LOAD        (pc_load),
    .PC_VALUE       (pc_value)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude();
    $display("counts: %0d compared, %0d bad", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // bound wait so a silent slave cannot hang the run
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] s, output logic [7:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    dat_i <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    `CHK("ack", 1'b1, ack)
    `CHK("dat_o upper", 24'h000000, dat_o[31:8])
  endtask

  task automatic wrr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1, q);
  endtask

  task automatic chk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 4'h1, q);
    `CHK($sformatf("reg %h", idx), e, q)
  endtask

  // a wake pulse during hold must be ignored
  task automatic rel(input logic [2:0] c);
    @(posedge clk);
    hold <= 1'b1;
    wake <= 1'b1;
    by_irq <= 1'b1;
    @(posedge clk);
    hold <= 1'b0;
    wake <= 1'b0;
    cause <= c;
    #1 `CHK("pc_load in hold", 1'b0, pc_load)
    @(posedge clk);
    #1 `CHK("pc_load release", 1'b1, pc_load)
    `CHK("pc_value release", 13'h0000, pc_value)
  endtask

  task automatic wk(input logic irq, input logic [2:0] ic,
                    input logic [7:0] pf, input logic u, input logic [7:0] pi,
                    input logic [7:0] pm, input logic [7:0] pd,
                    input logic [12:0] epc);
    @(posedge clk);
    wake <= 1'b1;
    by_irq <= irq;
    ictl <= ic;
    pflag <= pf;
    upd <= u;
    pidx <= pi;
    pmask <= pm;
    pdata <= pd;
    @(posedge clk);
    wake <= 1'b0;
    upd <= 1'b0;
    #1 `CHK("pc_load wake", 1'b1, pc_load)
    `CHK("pc_value wake", epc, pc_value)
    @(posedge clk);
    #1 `CHK("pc_load pulse", 1'b0, pc_load)
  endtask

  always @(posedge clk)
  begin
    ncyc++;
    if (ncyc == 5000)
    begin
      n_fail++;
      $display("BAD run length exp done got hang");
      conclude();
    end
  end

  initial
  begin
    {rst, cyc, stb, we, hold, wake, by_irq, upd} = 8'h80;
    {adr, sel, dat_i, cause, ictl} = '0;
    {pflag, pidx, pmask, pdata} = '0;
    cur_pc = 13'h0123;
    n_fail = 0;
    n_tests = 0;
    ncyc = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 `CHK("ack after reset", 1'b0, ack)
    `CHK("pc_load after reset", 1'b0, pc_load)
    foreach (ROWS[i])
      chk(ROWS[i][23:16], ROWS[i][15:8]);
    foreach (ROWS[i])
      if (ROWS[i][24])
      begin
        wrr(ROWS[i][23:16], 8'hff);
        chk(ROWS[i][23:16], ROWS[i][7:0]);
      end
    $display("test table done");
    foreach (OTHER[i])
    begin
      wrr(8'h11, 8'hff);
      wrr(8'h85, 8'h00);
      rel(OTHER[i]);
      chk(8'h11, 8'h00);
      chk(8'h85, 8'hff);
      chk(8'h10, 8'h3f);
      chk(8'h8e, 8'h0b);
      chk(8'h15, 8'hff);
    end
    $display("test other resets done");
    wrr(8'h81, 8'h00);
    rel(3'h3);
    chk(8'h10, 8'h00);
    chk(8'h8e, 8'h0a);
    chk(8'h81, 8'hff);
    chk(8'h16, 8'hff);
    $display("test brownout done");
    rel(3'h0);
    chk(8'h15, 8'h00);
    chk(8'h8e, 8'h08);
    bus(1'b1, 8'h11, 8'h5a, 4'he, q);
    chk(8'h11, 8'h00);
    $display("test power-on done");
    wrr(8'h0b, 8'h80);
    wrr(8'h17, 8'h3f);
    wk(1'b1, 3'h5, 8'hff, 1'b1, 8'h17, 8'h0f, 8'h05, 13'h0004);
    chk(8'h0b, 8'h85);
    chk(8'h0c, 8'hf7);
    chk(8'h17, 8'h35);
    wrr(8'h0b, 8'h00);
    wk(1'b1, 3'h0, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 13'h0124);
    wrr(8'h0b, 8'h80);
    wk(1'b0, 3'h2, 8'h01, 1'b0, 8'h00, 8'h00, 8'h00, 13'h0124);
    chk(8'h0b, 8'h80);
    $display("test wake done");
    conclude();
  end
endmodule
